// >>> hdl/lcd_bus_if.sv
`timescale 1ns/100ps
interface lcd_bus_if;
  logic [7:0] hostData;
  logic [7:0] hostDataOe;
  logic [7:0] devData;
  logic [7:0] devDataOe;
  logic       initPinLow;
  logic       selectLow;
  logic       selectHigh;
  logic       cmdOrPixelSel;
  logic       rdPin;
  logic       wrPin;
  logic       busFamilySel;
  logic       parallelSel;
  logic [7:0] busLevel;

  // Undriven bits float high through a board pull-up
  assign busLevel = (devData & devDataOe) | (hostData & hostDataOe & ~devDataOe)
                  | ~(devDataOe | hostDataOe);

  modport device (
    input  busLevel, initPinLow, selectLow, selectHigh, cmdOrPixelSel,
    input  rdPin, wrPin, busFamilySel, parallelSel,
    output devData, devDataOe
  );
  modport host (
    input  busLevel,
    output hostData, hostDataOe, initPinLow, selectLow, selectHigh, cmdOrPixelSel,
    output rdPin, wrPin, busFamilySel, parallelSel
  );
endinterface

// >>> hdl/lcd_bus_params.svh
`ifndef LCD_BUS_PARAMS_SVH
`define LCD_BUS_PARAMS_SVH
// Overview of operation
// - Init pin held low keeps device initialised.
// - 80-style: read strobe low drives data bus.
// - 68-style: read pin is active-high enable clock.
// - 80-style: data captured on write strobe fall.
// - 68-style: write pin is direction, high reads.
// - Serial entry: D0-D5 undriven and ignored.
// - Serial entry: host holds both strobes fixed.
// - Serial entry: no read path at all.
// - Select line high pixel data, low command.

`define MCLK_PERIOD_NS  20
`define HOST_PHASE_NS   200
`define HOST_PHASE_CYC  ((`HOST_PHASE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_WRITE       8'h08
`define REG_READ        8'h0C

`define CTRL_FAM68_BIT  0
`define CTRL_PAR_BIT    1
`define CTRL_INIT_BIT   2
`define CTRL_RESET      3'h2
`define XFER_PIXEL_BIT  8
`define STATUS_BUSY_BIT 0

`define PIN_COUNT       16
// Idle pin levels with init still held
`define PIN_RESET       16'h4DFF
`endif

// >>> hdl/lcd_bus_pkg.sv
package lcd_bus_pkg;
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} host_state_t;
  typedef logic [7:0] bus_byte_t;
endpackage

// >>> hdl/lcd_port_device.sv
`timescale 1ns/100ps
`include "lcd_bus_params.svh"
module lcd_port_device import lcd_bus_pkg::*; (
  // Clock and reset
  input  wire logic      mclk,
  input  wire logic      rstn,
  // Bus pins
  lcd_bus_if.device      bus,
  // User side
  output logic           rxValid,
  output bus_byte_t      rxData,
  output logic           rxIsPixel,
  output logic           readReq,
  input  wire bus_byte_t readData,
  output logic           initActive,
  output logic           serialMode
);
  logic [`PIN_COUNT-1:0] pinRaw;
  logic [`PIN_COUNT-1:0] s1;
  logic [`PIN_COUNT-1:0] s2;
  logic [`PIN_COUNT-1:0] s3;
  logic [`PIN_COUNT-1:0] filt;
  logic [`PIN_COUNT-1:0] prev;
  logic                  fInit;
  logic                  fSelLow;
  logic                  fSelHigh;
  logic                  fCmd;
  logic                  fRd;
  logic                  fWr;
  logic                  fFam;
  logic                  fPar;
  bus_byte_t             fData;
  logic                  pRd;
  logic                  pWr;
  logic                  live;
  logic                  writeHit;
  logic                  readHit;
  logic                  readOn;

  localparam logic [`PIN_COUNT-1:0] PinIdle = `PIN_RESET;

  function automatic logic chipSelected(input logic lowSel, input logic highSel);
    return !lowSel && highSel;
  endfunction

  assign pinRaw = {bus.initPinLow, bus.selectLow, bus.selectHigh, bus.cmdOrPixelSel,
                   bus.rdPin, bus.wrPin, bus.busFamilySel, bus.parallelSel, bus.busLevel};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1 <= `PIN_RESET;
      s2 <= `PIN_RESET;
      s3 <= `PIN_RESET;
    end else begin
      s1 <= pinRaw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `PIN_COUNT; i++) begin : gFilt
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          filt[i] <= PinIdle[i];
        end else if (s2[i] == s3[i]) begin
          filt[i] <= s3[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prev <= `PIN_RESET;
    end else begin
      prev <= filt;
    end
  end

  assign {fInit, fSelLow, fSelHigh, fCmd, fRd, fWr, fFam, fPar, fData} = filt;
  assign pRd = prev[11];
  assign pWr = prev[10];

  // Parallel, selected and out of init
  assign live = fInit && fPar && chipSelected(fSelLow, fSelHigh);

  always_comb begin
    if (fFam) begin
      writeHit = pRd && !fRd && !fWr;
      readHit  = !pRd && fRd && fWr;
      readOn   = fRd && fWr;
    end else begin
      writeHit = pWr && !fWr;
      readHit  = pRd && !fRd;
      readOn   = !fRd;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxValid   <= 1'b0;
      rxData    <= 8'h00;
      rxIsPixel <= 1'b0;
    end else begin
      rxValid <= live && writeHit;
      if (live && writeHit) begin
        rxData    <= fData;
        rxIsPixel <= fCmd;
      end
    end
  end

  // Serial mode leaves live low so no read is ever served
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readReq       <= 1'b0;
      bus.devData   <= 8'h00;
      bus.devDataOe <= 8'h00;
    end else begin
      readReq <= live && readHit;
      if (live && readHit) begin
        bus.devData <= readData;
      end
      bus.devDataOe <= (live && readOn) ? 8'hFF : 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      initActive <= 1'b1;
      serialMode <= 1'b0;
    end else begin
      initActive <= !fInit;
      serialMode <= !fPar;
    end
  end
endmodule

// >>> hdl/lcd_port_host.sv
`timescale 1ns/100ps
`include "lcd_bus_params.svh"
module lcd_port_host import lcd_bus_pkg::*; (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  output logic             busy,
  // Bus pins
  lcd_bus_if.host          bus
);
  host_state_t state;
  logic [2:0]  ctrl;
  logic [7:0]  phaseCnt;
  logic        txRead;
  bus_byte_t   readByte;
  bus_byte_t   s1;
  bus_byte_t   s2;
  bus_byte_t   s3;
  bus_byte_t   dFilt;
  logic        fam68;
  logic        startOk;
  logic        phaseDone;
  logic        start;
  logic        startRead;
  logic        setupEnd;
  logic        strobeEnd;
  logic        holdEnd;

  function automatic logic isXferAddr(input logic [7:0] addr);
    return addr == `REG_WRITE || addr == `REG_READ;
  endfunction

  assign fam68     = ctrl[`CTRL_FAM68_BIT];
  assign startOk   = state == H_IDLE && ctrl[`CTRL_PAR_BIT] && !ctrl[`CTRL_INIT_BIT];
  assign phaseDone = phaseCnt == 8'(`HOST_PHASE_CYC - 1);
  assign start     = startOk && regWr && isXferAddr(regAddr);
  assign startRead = regAddr == `REG_READ;
  assign setupEnd  = state == H_SETUP && phaseDone;
  assign strobeEnd = state == H_STROBE && phaseDone;
  assign holdEnd   = state == H_HOLD && phaseDone;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `CTRL_RESET;
    end else if (regWr && regAddr == `REG_CTRL && state == H_IDLE) begin
      ctrl <= regWdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        `REG_CTRL:   regRdata <= {29'h0, ctrl};
        `REG_STATUS: regRdata <= {31'h0, busy};
        `REG_READ:   regRdata <= {24'h0, readByte};
        default:     regRdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1    <= 8'h00;
      s2    <= 8'h00;
      s3    <= 8'h00;
    end else begin
      s1 <= bus.busLevel;
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : gFilt
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          dFilt[b] <= 1'b0;
        end else if (s2[b] == s3[b]) begin
          dFilt[b] <= s3[b];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus.initPinLow   <= 1'b1;
      bus.busFamilySel <= 1'b0;
      bus.parallelSel  <= 1'b1;
    end else begin
      bus.initPinLow   <= !ctrl[`CTRL_INIT_BIT];
      bus.busFamilySel <= fam68;
      bus.parallelSel  <= ctrl[`CTRL_PAR_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= H_IDLE;
    end else begin
      case (state)
        H_IDLE: begin
          if (start) begin
            state <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (phaseDone) begin
            state <= H_STROBE;
          end
        end
        H_STROBE: begin
          if (phaseDone) begin
            state <= H_HOLD;
          end
        end
        H_HOLD: begin
          if (phaseDone) begin
            state <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // Phase counter restarts at every phase boundary
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phaseCnt <= 8'h00;
    end else if (state == H_IDLE || phaseDone) begin
      phaseCnt <= 8'h00;
    end else begin
      phaseCnt <= phaseCnt + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end else if (holdEnd) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      txRead <= 1'b0;
    end else if (start) begin
      txRead <= startRead;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readByte <= 8'h00;
    end else if (strobeEnd && txRead) begin
      readByte <= dFilt;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus.selectLow  <= 1'b1;
      bus.selectHigh <= 1'b0;
    end else if (start) begin
      bus.selectLow  <= 1'b0;
      bus.selectHigh <= 1'b1;
    end else if (holdEnd) begin
      bus.selectLow  <= 1'b1;
      bus.selectHigh <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus.cmdOrPixelSel <= 1'b0;
      bus.hostData      <= 8'h00;
    end else if (start) begin
      bus.cmdOrPixelSel <= regWdata[`XFER_PIXEL_BIT];
      bus.hostData      <= regWdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus.hostDataOe <= 8'h00;
    end else if (start) begin
      bus.hostDataOe <= startRead ? 8'h00 : 8'hFF;
    end else if (holdEnd) begin
      bus.hostDataOe <= 8'h00;
    end
  end

  // Read strobe or enable clock, idle level set by the bus style
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus.rdPin <= 1'b1;
    end else if (state == H_IDLE || strobeEnd) begin
      bus.rdPin <= !fam68;
    end else if (setupEnd && (fam68 || txRead)) begin
      bus.rdPin <= fam68;
    end
  end

  // Write strobe or direction line
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus.wrPin <= 1'b1;
    end else if (state == H_IDLE) begin
      bus.wrPin <= (start && fam68) ? startRead : 1'b1;
    end else if (setupEnd && !fam68 && !txRead) begin
      bus.wrPin <= 1'b0;
    end else if ((strobeEnd && !fam68) || holdEnd) begin
      bus.wrPin <= 1'b1;
    end
  end
endmodule

// >>> verification/lcd_host_bus_port_monitor.sv
`timescale 1ns/100ps
module lcd_host_bus_port_monitor (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rstn,
  // Bus pins
  input wire logic [7:0] hostDataOe,
  input wire logic [7:0] devDataOe,
  input wire logic       initPinLow,
  input wire logic       selectLow,
  input wire logic       selectHigh,
  input wire logic       rdPin,
  input wire logic       wrPin,
  input wire logic       busFamilySel,
  input wire logic       parallelSel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic live;
  assign live = !selectLow && selectHigh && parallelSel && initPinLow;
  init_quiet_a: assert property (!initPinLow [*6] |-> devDataOe == 8'h00)
    else $error("bus driven in init");
  rd80_drive_a: assert property ($fell(rdPin) && !busFamilySel && live
    |-> ##[3:8] devDataOe == 8'hFF)
    else $error("80 read not driven");
  rd68_drive_a: assert property ($rose(rdPin) && busFamilySel && wrPin && live
    |-> ##[3:8] devDataOe == 8'hFF)
    else $error("68 read not driven");
  wr68_quiet_a: assert property (busFamilySel && !wrPin |-> devDataOe == 8'h00)
    else $error("bus driven in 68 write");
  serial_quiet_a: assert property (!parallelSel [*6]
    |-> devDataOe == 8'h00)
    else $error("bus driven in serial mode");
  strobe_fixed_a: assert property (!parallelSel && !$past(parallelSel)
    && $stable(busFamilySel) |-> $stable(rdPin) && $stable(wrPin))
    else $error("strobe toggled in serial mode");
  unsel_quiet_a: assert property ((selectLow || !selectHigh) [*6]
    |-> devDataOe == 8'h00)
    else $error("bus driven while unselected");
  no_clash_a: assert property (devDataOe != 8'h00 |-> hostDataOe == 8'h00)
    else $error("both ends drive bus");
  cover property ($fell(wrPin) && !busFamilySel && live);
  cover property ($rose(rdPin) && busFamilySel && wrPin && live);
  cover property (!parallelSel && !busFamilySel);
endmodule

// >>> verification/lcd_host_bus_port_tb.sv
`timescale 1ns/100ps
`include "lcd_bus_params.svh"
module lcd_host_bus_port_tb import lcd_bus_pkg::*;;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdata;
  logic        busy, rxValid, rxIsPixel, readReq, initActive, serialMode, lastPix;
  bus_byte_t   rxData, lastRx;
  bus_byte_t   readData = 8'h00;
  int          failCount = 0;
  int          cmpCount = 0;
  int          rxCount = 0;
  int          rdCount = 0;

  always #10 mclk = ~mclk;

  lcd_bus_if u_lcd_bus_if ();
  lcd_port_host u_lcd_port_host (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .busy(busy), .bus(u_lcd_bus_if.host));
  lcd_port_device u_lcd_port_device (.mclk(mclk), .rstn(rstn), .bus(u_lcd_bus_if.device),
    .rxValid(rxValid), .rxData(rxData), .rxIsPixel(rxIsPixel), .readReq(readReq),
    .readData(readData), .initActive(initActive), .serialMode(serialMode));
  lcd_host_bus_port_monitor mon (.mclk(mclk), .rstn(rstn),
    .hostDataOe(u_lcd_bus_if.hostDataOe), .devDataOe(u_lcd_bus_if.devDataOe),
    .initPinLow(u_lcd_bus_if.initPinLow), .selectLow(u_lcd_bus_if.selectLow),
    .selectHigh(u_lcd_bus_if.selectHigh), .rdPin(u_lcd_bus_if.rdPin),
    .wrPin(u_lcd_bus_if.wrPin), .busFamilySel(u_lcd_bus_if.busFamilySel),
    .parallelSel(u_lcd_bus_if.parallelSel));

  always @(posedge mclk) begin
    if (rxValid === 1'b1) begin
      rxCount++;
      lastRx = rxData;
      lastPix = rxIsPixel;
    end
    if (readReq === 1'b1) begin
      rdCount++;
    end
  end

  function automatic logic [31:0] xw(input bus_byte_t b, input logic p);
    return {23'h0, p, b};
  endfunction

  task conclude;
    $display("fails %0d compares %0d", failCount, cmpCount);
    if (failCount == 0 && cmpCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  // Bounded wait for the host to finish, then let the device release
  task waitIdle;
    int n;
    n = 0;
    repeat (3) @(posedge mclk);
    #1;
    while (busy !== 1'b0) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 200) begin
        failCount++;
        $display("mismatch at %0t: busy timeout", $time);
        conclude();
      end
    end
    repeat (8) @(posedge mclk);
  endtask

  initial begin
    #1000000;
    failCount++;
    $display("mismatch at %0t: run timeout", $time);
    conclude();
  end

  initial begin
    logic [31:0] rd;
    bus_byte_t   b;
    logic        p;
    int          m, k, n0, r0;
    void'($urandom(32'h4265));
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (8) @(posedge mclk);
    rreg(`REG_CTRL, rd);
    chk(rd, {29'h0, `CTRL_RESET});
    rreg(8'h10, rd);
    chk(rd, 32'h0);
    chk({31'h0, initActive}, 32'h0);
    for (m = 0; m < 2; m++) begin
      wreg(`REG_CTRL, {30'h0, 1'b1, m[0]});
      waitIdle();
      for (k = 0; k < 5; k++) begin
        b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
        p = 1'($urandom);
        n0 = rxCount;
        wreg(`REG_WRITE, xw(b, p));
        rreg(`REG_STATUS, rd);
        chk(rd, 32'h1);
        waitIdle();
        chk(32'(rxCount - n0), 32'h1);
        chk(xw(lastRx, lastPix), xw(b, p));
        b = 8'($urandom);
        @(posedge mclk);
        readData <= b;
        n0 = rdCount;
        wreg(`REG_READ, xw(8'h00, p));
        waitIdle();
        rreg(`REG_READ, rd);
        chk({24'h0, rd[7:0]}, {24'h0, b});
        chk(32'(rdCount - n0), 32'h1);
      end
    end
    wreg(`REG_CTRL, 32'h6);
    waitIdle();
    chk({31'h0, initActive}, 32'h1);
    n0 = rxCount;
    wreg(`REG_WRITE, xw(8'h5A, 1'b1));
    waitIdle();
    chk(32'(rxCount - n0), 32'h0);
    for (m = 0; m < 2; m++) begin
      wreg(`REG_CTRL, {31'h0, m[0]});
      waitIdle();
      chk({31'h0, serialMode}, 32'h1);
      n0 = rxCount;
      r0 = rdCount;
      wreg(`REG_WRITE, xw(8'hC3, 1'b0));
      rreg(`REG_STATUS, rd);
      chk(rd, 32'h0);
      waitIdle();
      wreg(`REG_READ, xw(8'h00, 1'b1));
      waitIdle();
      chk(32'(rxCount - n0), 32'h0);
      chk(32'(rdCount - r0), 32'h0);
    end
    conclude();
  end
endmodule
